// [verilog/oag_pkg.sv]
// operand address generator shared constants and types
package oag_pkg;
    // addressing modes supplied by decode
    typedef enum logic [2:0]
    {
        OAG_MODE_DIRECT   = 3'h0,
        OAG_MODE_INDIRECT = 3'h1,
        OAG_MODE_REGISTER = 3'h2,
        OAG_MODE_REGSPEC  = 3'h3,
        OAG_MODE_IMMED    = 3'h4,
        OAG_MODE_INDEXED  = 3'h5,
        OAG_MODE_BIT      = 3'h6,
        OAG_MODE_STACK    = 3'h7
    } oag_mode_t;

    // target address spaces
    typedef enum logic [2:0]
    {
        OAG_SPACE_NONE    = 3'h0,
        OAG_SPACE_IRAM    = 3'h1,
        OAG_SPACE_SPECIAL = 3'h2,
        OAG_SPACE_XRAM    = 3'h3,
        OAG_SPACE_CODE    = 3'h4,
        OAG_SPACE_REG     = 3'h5
    } oag_space_t;

    // indirect pointer select
    localparam logic [1:0] OAG_PTR_IDX0 = 2'h0;
    localparam logic [1:0] OAG_PTR_IDX1 = 2'h1;
    localparam logic [1:0] OAG_PTR_SP   = 2'h2;
    localparam logic [1:0] OAG_PTR_DP   = 2'h3;

    // indexed base select
    localparam logic OAG_BASE_DP = 1'b0;
    localparam logic OAG_BASE_PC = 1'b1;

    // stack action
    localparam logic [1:0] OAG_STK_NONE = 2'h0;
    localparam logic [1:0] OAG_STK_PUSH = 2'h1;
    localparam logic [1:0] OAG_STK_POP  = 2'h2;

    // address map
    localparam logic [7:0] OAG_SPECIAL_BASE = 8'h80;
    localparam logic [7:0] OAG_BITRAM_BASE  = 8'h20;
    localparam logic [3:0] OAG_BITREG_LO0   = 4'h0;
    localparam logic [3:0] OAG_BITREG_LO8   = 4'h8;
    localparam logic [7:0] OAG_SP_RESET     = 8'h07;
    localparam logic [1:0] OAG_BANK_RESET   = 2'h0;
endpackage : oag_pkg

// [verilog/oag_bit_decode.sv]
// bit address to byte address and bit index decoder
module oag_bit_decode
    import oag_pkg::*;
(
    input  wire logic [7:0] bit_addr,      // bit address from opcode
    output logic      [7:0] byte_addr,     // byte holding the bit
    output logic      [2:0] bit_index,     // bit within the byte
    output logic            in_special     // bit lies in special register space
);
    // low area packs 128 bits into bytes 20h..2Fh, upper area uses special register bytes
    always_comb
    begin
        bit_index  = bit_addr[2:0];
        in_special = bit_addr[7];
        if (bit_addr[7])
            byte_addr = {bit_addr[7:3], 3'h0};
        else
            byte_addr = OAG_BITRAM_BASE + {4'h0, bit_addr[6:3]};
    end
endmodule : oag_bit_decode

// [verilog/oag_top.sv]
// operand address generator for the 8-bit core
module oag_top
    import oag_pkg::*;
(
    input  wire logic                sys_clk,       // core clock
    input  wire logic                reset,         // synchronous reset, high
    input  wire logic                op_valid,      // decode presents a request
    input  wire oag_pkg::oag_mode_t  op_mode,       // addressing mode
    input  wire logic [7:0]          op_field,      // address or bit field byte
    input  wire logic [2:0]          op_reg_sel,    // register field of opcode
    input  wire logic [1:0]          op_ptr_sel,    // indirect pointer select
    input  wire logic                op_base_sel,   // indexed base select
    input  wire logic                op_write,      // request is a write
    input  wire logic [1:0]          op_stack,      // push/pop stack action
    input  wire logic [7:0]          idx_reg_zero,  // index register zero value
    input  wire logic [7:0]          idx_reg_one,   // index register one value
    input  wire logic [7:0]          accumulator,   // accumulator value
    input  wire logic [15:0]         data_pointer,  // data pointer value
    input  wire logic [15:0]         prog_counter,  // program counter value
    input  wire logic                bank_select_low,  // status word bank bit 0
    input  wire logic                bank_select_high, // status word bank bit 1
    input  wire logic                sp_load,       // load stack pointer
    input  wire logic [7:0]          sp_load_val,   // value to load
    output logic                     addr_valid,    // address result valid
    output oag_pkg::oag_space_t      addr_space,    // target space
    output logic [15:0]              addr_out,      // target address
    output logic [2:0]               addr_bit,      // bit index for bit ops
    output logic                     addr_is_bit,   // bit operation
    output logic                     addr_write,    // write strobe to target
    output logic                     addr_fault,    // request refused
    output logic                     fetch_operand, // operand bytes follow opcode
    output logic [7:0]               stack_ptr      // stack pointer
);
    // bank base: select value times eight
    function automatic logic [7:0] oag_bank_base(input logic [1:0] bank);
        oag_bank_base = {3'h0, bank, 3'h0};
    endfunction : oag_bank_base

    // true when a byte address is a bit-addressable special register
    function automatic logic oag_special_bitable(input logic [7:0] a);
        oag_special_bitable = a[7] && (a[3:0] == OAG_BITREG_LO0 || a[3:0] == OAG_BITREG_LO8);
    endfunction : oag_special_bitable

    logic [7:0]  bit_byte;
    logic [2:0]  bit_idx;
    logic        bit_in_special;
    logic [1:0]  bank_now;
    logic [7:0]  sp_reg;
    logic [7:0]  sp_next;
    logic        valid_reg;
    logic        valid_next;
    oag_space_t  space_reg;
    oag_space_t  space_next;
    logic [15:0] addr_reg;
    logic [15:0] addr_next;
    logic [2:0]  bit_reg;
    logic [2:0]  bit_next;
    logic        isbit_reg;
    logic        isbit_next;
    logic        wr_reg;
    logic        wr_next;
    logic        fault_reg;
    logic        fault_next;
    logic        fetch_reg;
    logic        fetch_next;

    // bit address decode
    oag_bit_decode u_bit_decode
    (
        .bit_addr   (op_field),
        .byte_addr  (bit_byte),
        .bit_index  (bit_idx),
        .in_special (bit_in_special)
    );

    assign bank_now = {bank_select_high, bank_select_low};

    // stack pointer next value
    always_comb
    begin
        sp_next = sp_reg;
        if (sp_load)
            sp_next = sp_load_val;
        else if (op_valid && op_mode == OAG_MODE_STACK && op_stack == OAG_STK_PUSH)
            sp_next = sp_reg + 8'h01;
        else if (op_valid && op_mode == OAG_MODE_STACK && op_stack == OAG_STK_POP)
            sp_next = sp_reg - 8'h01;
    end

    // address result next values
    always_comb
    begin
        valid_next = op_valid;
        space_next = OAG_SPACE_NONE;
        addr_next  = 16'h0000;
        bit_next   = 3'h0;
        isbit_next = 1'b0;
        wr_next    = 1'b0;
        fault_next = 1'b0;
        fetch_next = 1'b0;
        if (op_valid)
        begin
            unique case (op_mode)
                OAG_MODE_DIRECT:
                begin
                    addr_next  = {8'h00, op_field};
                    // upper half is special registers, never external
                    space_next = OAG_SPACE_IRAM;
                    if (op_field >= OAG_SPECIAL_BASE)
                        space_next = OAG_SPACE_SPECIAL;
                    wr_next    = op_write;
                    fetch_next = 1'b1;
                end
                OAG_MODE_INDIRECT:
                begin
                    wr_next = op_write;
                    unique case (op_ptr_sel)
                        OAG_PTR_IDX0:
                        begin
                            addr_next  = {8'h00, idx_reg_zero};
                            space_next = OAG_SPACE_IRAM;
                        end
                        OAG_PTR_IDX1:
                        begin
                            addr_next  = {8'h00, idx_reg_one};
                            space_next = OAG_SPACE_IRAM;
                        end
                        OAG_PTR_SP:
                        begin
                            addr_next  = {8'h00, sp_reg};
                            space_next = OAG_SPACE_IRAM;
                        end
                        OAG_PTR_DP:
                        begin
                            addr_next  = data_pointer;
                            space_next = OAG_SPACE_XRAM;
                        end
                    endcase
                end
                OAG_MODE_REGISTER:
                begin
                    // bank base plus register number
                    addr_next  = {8'h00, oag_bank_base(bank_now)
                                  | {5'h00, op_reg_sel}};
                    space_next = OAG_SPACE_IRAM;
                    wr_next    = op_write;
                end
                OAG_MODE_REGSPEC:
                begin
                    space_next = OAG_SPACE_REG;
                    wr_next    = op_write;
                end
                OAG_MODE_IMMED:
                begin
                    addr_next  = prog_counter;
                    space_next = OAG_SPACE_CODE;
                    fetch_next = 1'b1;
                end
                OAG_MODE_INDEXED:
                begin
                    // carry out of bit 15 is dropped
                    addr_next  = 16'((op_base_sel == OAG_BASE_PC ? prog_counter : data_pointer)
                                     + {8'h00, accumulator});
                    space_next = OAG_SPACE_CODE;
                    fault_next = op_write;
                end
                OAG_MODE_BIT:
                begin
                    addr_next  = {8'h00, bit_byte};
                    space_next = bit_in_special ? OAG_SPACE_SPECIAL : OAG_SPACE_IRAM;
                    bit_next   = bit_idx;
                    isbit_next = 1'b1;
                    wr_next    = op_write;
                    fetch_next = 1'b1;
                    // only special registers at low nibble 0h/8h carry bits
                    if (bit_in_special && !oag_special_bitable(bit_byte))
                    begin
                        fault_next = 1'b1;
                        wr_next    = 1'b0;
                    end
                end
                OAG_MODE_STACK:
                begin
                    // push writes at the incremented pointer
                    addr_next  = {8'h00, (op_stack == OAG_STK_PUSH) ? sp_reg + 8'h01
                                                                    : sp_reg};
                    space_next = OAG_SPACE_IRAM;
                    wr_next    = (op_stack == OAG_STK_PUSH);
                end
            endcase
        end
    end

    // registers
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sp_reg    <= OAG_SP_RESET;
            valid_reg <= 1'b0;
            space_reg <= OAG_SPACE_NONE;
            addr_reg  <= 16'h0000;
            bit_reg   <= 3'h0;
            isbit_reg <= 1'b0;
            wr_reg    <= 1'b0;
            fault_reg <= 1'b0;
            fetch_reg <= 1'b0;
        end
        else
        begin
            sp_reg    <= sp_next;
            valid_reg <= valid_next;
            space_reg <= space_next;
            addr_reg  <= addr_next;
            bit_reg   <= bit_next;
            isbit_reg <= isbit_next;
            wr_reg    <= wr_next;
            fault_reg <= fault_next;
            fetch_reg <= fetch_next;
        end
    end

    assign addr_valid    = valid_reg;
    assign addr_space    = space_reg;
    assign addr_out      = addr_reg;
    assign addr_bit      = bit_reg;
    assign addr_is_bit   = isbit_reg;
    assign addr_write    = wr_reg;
    assign addr_fault    = fault_reg;
    assign fetch_operand = fetch_reg;
    assign stack_ptr     = sp_reg;

    // assertions
    property p_special_direct_only;
        @(posedge sys_clk) disable iff (reset)
        (addr_space == OAG_SPACE_SPECIAL) |-> (addr_out[7] && addr_out[15:8] == 8'h00);
    endproperty
    a_special_direct_only: assert property (p_special_direct_only)
        else $error("special space outside 80h-FFh");

    property p_indirect_not_special;
        @(posedge sys_clk) disable iff (reset)
        (op_valid && op_mode == OAG_MODE_INDIRECT) |=> (addr_space != OAG_SPACE_SPECIAL);
    endproperty
    a_indirect_not_special: assert property (p_indirect_not_special)
        else $error("indirect hit special space");

    property p_direct_high;
        @(posedge sys_clk) disable iff (reset)
        (op_valid && op_mode == OAG_MODE_DIRECT && op_field[7])
            |=> (addr_space == OAG_SPACE_SPECIAL && addr_out[7:0] == $past(op_field));
    endproperty
    a_direct_high: assert property (p_direct_high) else $error("direct high not special");

    property p_reg_bank;
        @(posedge sys_clk) disable iff (reset)
        (op_valid && op_mode == OAG_MODE_REGISTER)
            |=> (addr_out[7:0] == {3'h0, $past(bank_now), $past(op_reg_sel)});
    endproperty
    a_reg_bank: assert property (p_reg_bank)
        else $error("register bank address wrong");

    property p_indexed_sum;
        @(posedge sys_clk) disable iff (reset)
        (op_valid && op_mode == OAG_MODE_INDEXED && op_base_sel == OAG_BASE_DP)
            |=> (addr_out == 16'($past(data_pointer) + {8'h00, $past(accumulator)}));
    endproperty
    a_indexed_sum: assert property (p_indexed_sum) else $error("indexed sum wrong");

    property p_indexed_no_write;
        @(posedge sys_clk) disable iff (reset)
        (addr_space == OAG_SPACE_CODE) |-> !addr_write;
    endproperty
    a_indexed_no_write: assert property (p_indexed_no_write)
        else $error("write to code");

    property p_push_incr;
        @(posedge sys_clk) disable iff (reset)
        (op_valid && op_mode == OAG_MODE_STACK && op_stack == OAG_STK_PUSH && !sp_load)
            |=> (stack_ptr == $past(stack_ptr) + 8'h01 && addr_out[7:0] == stack_ptr);
    endproperty
    a_push_incr: assert property (p_push_incr) else $error("push not pre-increment");

    property p_bit_ram;
        @(posedge sys_clk) disable iff (reset)
        (addr_is_bit && addr_space == OAG_SPACE_IRAM)
            |-> (addr_out[7:4] == 4'h2);
    endproperty
    a_bit_ram: assert property (p_bit_ram) else $error("bit ram byte out of range");

    property p_bit_aligned;
        @(posedge sys_clk) disable iff (reset)
        (addr_is_bit && addr_space == OAG_SPACE_SPECIAL) |-> oag_special_bitable(addr_out[7:0]);
    endproperty
    a_bit_aligned: assert property (p_bit_aligned) else $error("bit byte not bit addressable");

    property p_dp_xram;
        @(posedge sys_clk) disable iff (reset)
        (op_valid && op_mode == OAG_MODE_INDIRECT && op_ptr_sel == OAG_PTR_DP)
            |=> (addr_space == OAG_SPACE_XRAM && addr_out == $past(data_pointer));
    endproperty
    a_dp_xram: assert property (p_dp_xram) else $error("data pointer indirect wrong");

    c_special_access: cover property (@(posedge sys_clk) addr_valid
                                       && addr_space == OAG_SPACE_SPECIAL);
    c_bit_special: cover property (@(posedge sys_clk) addr_is_bit
                                    && addr_space == OAG_SPACE_SPECIAL);
    c_indexed_wrap: cover property (@(posedge sys_clk) addr_valid && addr_space == OAG_SPACE_CODE
                                     && addr_out < 16'h0100);
    c_bank3: cover property (@(posedge sys_clk) op_valid && op_mode == OAG_MODE_REGISTER
                              && bank_now == 2'h3);
endmodule : oag_top

// [test/oag_core_model.sv]
// core register file model that feeds index register values to the generator
module oag_core_model
(
    input  wire logic       bank_select_low,  // status word bank bit 0
    input  wire logic       bank_select_high, // status word bank bit 1
    output logic      [7:0] idx_reg_zero,     // register 0 of active bank
    output logic      [7:0] idx_reg_one       // register 1 of active bank
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] bank_ram [0:31]; // four banks of eight registers, RAM 0..31
    logic [4:0] bank_base;       // first byte of the active bank
    // fill the banks with distinct values, all at or above 80h
    initial
    begin
        for (int i = 0; i < 32; i++)
            bank_ram[i] = 8'hA0 + 8'(i);
    end
    // one active bank, base picked by the two select bits
    assign bank_base = {bank_select_high, bank_select_low, 3'h0};
    // index registers are the first two bytes of the active bank
    assign idx_reg_zero = bank_ram[bank_base];
    assign idx_reg_one  = bank_ram[bank_base + 5'h01];
endmodule : oag_core_model

// [test/test_oag_top.sv]
// self-checking bench for the operand address generator
module test_oag_top
    import oag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        oag_mode_t   mode;
        logic [7:0]  field;
        logic [2:0]  sel;
        logic        wr;
        logic [1:0]  bank;
        oag_space_t  space;
        logic [15:0] addr;
        logic [2:0]  bitn;
    } oag_row_t;
    logic        sys_clk;
    logic        reset;
    logic        op_valid;
    oag_mode_t   op_mode;
    logic [7:0]  op_field;
    logic [2:0]  op_sel;      // shared register, pointer and base select
    logic        op_write;
    logic [1:0]  op_stack;
    logic [1:0]  bank;
    logic        sp_load;
    logic [7:0]  sp_load_val;
    logic [7:0]  idx_reg_zero;
    logic [7:0]  idx_reg_one;
    logic [7:0]  accumulator;
    logic [15:0] data_pointer;
    logic [15:0] prog_counter;
    logic        addr_valid;
    oag_space_t  addr_space;
    logic [15:0] addr_out;
    logic [2:0]  addr_bit;
    logic        addr_is_bit;
    logic        addr_write;
    logic        addr_fault;
    logic        fetch_operand;
    logic [7:0]  stack_ptr;
    int          err_total;
    int          checks_done;
    // ordinary cases: inputs, then expected space, address and bit index
    oag_row_t rows [17] = '{
        '{OAG_MODE_DIRECT,8'h3E,3'h0,1'h0,2'h0,OAG_SPACE_IRAM,16'h003E,3'h0},
        '{OAG_MODE_DIRECT,8'h7F,3'h0,1'h1,2'h0,OAG_SPACE_IRAM,16'h007F,3'h0},
        '{OAG_MODE_DIRECT,8'h80,3'h0,1'h1,2'h0,OAG_SPACE_SPECIAL,16'h0080,3'h0},
        '{OAG_MODE_DIRECT,8'hFF,3'h0,1'h0,2'h0,OAG_SPACE_SPECIAL,16'h00FF,3'h0},
        '{OAG_MODE_INDIRECT,8'h00,3'h0,1'h0,2'h0,OAG_SPACE_IRAM,16'h00A0,3'h0},
        '{OAG_MODE_INDIRECT,8'h00,3'h1,1'h1,2'h3,OAG_SPACE_IRAM,16'h00B9,3'h0},
        '{OAG_MODE_INDIRECT,8'h00,3'h2,1'h0,2'h1,OAG_SPACE_IRAM,16'h0007,3'h0},
        '{OAG_MODE_INDIRECT,8'h00,3'h3,1'h1,2'h2,OAG_SPACE_XRAM,16'hFFFF,3'h0},
        '{OAG_MODE_REGISTER,8'h00,3'h5,1'h0,2'h2,OAG_SPACE_IRAM,16'h0015,3'h0},
        '{OAG_MODE_REGISTER,8'h00,3'h7,1'h1,2'h3,OAG_SPACE_IRAM,16'h001F,3'h0},
        '{OAG_MODE_REGISTER,8'h00,3'h0,1'h0,2'h1,OAG_SPACE_IRAM,16'h0008,3'h0},
        '{OAG_MODE_IMMED,8'h00,3'h0,1'h0,2'h0,OAG_SPACE_CODE,16'h1234,3'h0},
        '{OAG_MODE_INDEXED,8'h00,3'h0,1'h0,2'h0,OAG_SPACE_CODE,16'h0001,3'h0},
        '{OAG_MODE_INDEXED,8'h00,3'h1,1'h0,2'h0,OAG_SPACE_CODE,16'h1236,3'h0},
        '{OAG_MODE_BIT,8'h0A,3'h0,1'h0,2'h0,OAG_SPACE_IRAM,16'h0021,3'h2},
        '{OAG_MODE_BIT,8'hE3,3'h0,1'h0,2'h0,OAG_SPACE_SPECIAL,16'h00E0,3'h3},
        '{OAG_MODE_BIT,8'hCF,3'h0,1'h1,2'h0,OAG_SPACE_SPECIAL,16'h00C8,3'h7}
    };
    oag_top i_oag_top
    (
        .sys_clk          (sys_clk),
        .reset            (reset),
        .op_valid         (op_valid),
        .op_mode          (op_mode),
        .op_field         (op_field),
        .op_reg_sel       (op_sel),
        .op_ptr_sel       (op_sel[1:0]),
        .op_base_sel      (op_sel[0]),
        .op_write         (op_write),
        .op_stack         (op_stack),
        .idx_reg_zero     (idx_reg_zero),
        .idx_reg_one      (idx_reg_one),
        .accumulator      (accumulator),
        .data_pointer     (data_pointer),
        .prog_counter     (prog_counter),
        .bank_select_low  (bank[0]),
        .bank_select_high (bank[1]),
        .sp_load          (sp_load),
        .sp_load_val      (sp_load_val),
        .addr_valid       (addr_valid),
        .addr_space       (addr_space),
        .addr_out         (addr_out),
        .addr_bit         (addr_bit),
        .addr_is_bit      (addr_is_bit),
        .addr_write       (addr_write),
        .addr_fault       (addr_fault),
        .fetch_operand    (fetch_operand),
        .stack_ptr        (stack_ptr)
    );
    oag_core_model i_oag_core_model
    (
        .bank_select_low  (bank[0]),
        .bank_select_high (bank[1]),
        .idx_reg_zero     (idx_reg_zero),
        .idx_reg_one      (idx_reg_one)
    );
    // core clock, 100 ns period
    initial
    begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    // compare a value of up to 16 bits
    task automatic chk_vec(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk_vec
    // compare an address space code
    task automatic chk_space(input string name, input oag_space_t exp, input oag_space_t got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
        end
    endtask : chk_space
    // one request at the falling edge, results settled after the next rise
    task automatic send(input oag_mode_t m, input logic [7:0] f, input logic [2:0] s,
                        input logic w, input logic [1:0] stk, input logic [1:0] b);
        @(negedge sys_clk);
        op_valid = 1'h1;
        op_mode = m;
        op_field = f;
        op_sel = s;
        op_write = w;
        op_stack = stk;
        bank = b;
        sp_load = 1'h0;
        @(posedge sys_clk);
        #1;
    endtask : send
    // full comparison of one table row
    task automatic check_row(input oag_row_t r);
        logic fetch_exp;
        fetch_exp = r.mode inside {OAG_MODE_DIRECT, OAG_MODE_IMMED, OAG_MODE_BIT};
        chk_vec("addr_valid", 16'h0001, 16'(addr_valid));
        chk_space("addr_space", r.space, addr_space);
        chk_vec("addr_out", r.addr, addr_out);
        if (r.mode == OAG_MODE_BIT)
            chk_vec("addr_bit", 16'(r.bitn), 16'(addr_bit));
        chk_vec("addr_is_bit", 16'(r.mode == OAG_MODE_BIT), 16'(addr_is_bit));
        chk_vec("addr_write", 16'(r.wr), 16'(addr_write));
        chk_vec("addr_fault", 16'h0000, 16'(addr_fault));
        chk_vec("fetch_operand", 16'(fetch_exp), 16'(fetch_operand));
    endtask : check_row
    // counts, verdict and end of run
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    // watchdog at 400 cycles, well beyond the about 37 cycles the tests need
    initial
    begin
        #(400 * 100);
        err_total++;
        $display("unexpected watchdog: expected finish, seen timeout");
        test_done();
    end
    // main sequence
    initial
    begin
        {reset, op_valid, op_field, op_sel, op_write, op_stack, bank} = 18'h20000;
        op_mode = OAG_MODE_DIRECT;
        sp_load = 1'h0;
        sp_load_val = 8'h00;
        accumulator = 8'h02;
        data_pointer = 16'hFFFF;
        prog_counter = 16'h1234;
        err_total = 0;
        checks_done = 0;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'h0;
        @(posedge sys_clk);
        #1;
        chk_vec("addr_valid", 16'h0000, 16'(addr_valid));
        chk_space("addr_space", OAG_SPACE_NONE, addr_space);
        chk_vec("stack_ptr", 16'h0007, 16'(stack_ptr));
        $display("test reset done");
        foreach (rows[i])
        begin
            send(rows[i].mode, rows[i].field, rows[i].sel, rows[i].wr, 2'h0, rows[i].bank);
            check_row(rows[i]);
        end
        $display("test table done");
        // two pushes back to back, then a pop
        send(OAG_MODE_STACK, 8'h00, 3'h0, 1'h0, OAG_STK_PUSH, 2'h0);
        chk_vec("stack_ptr", 16'h0008, 16'(stack_ptr));
        chk_vec("addr_out", 16'h0008, addr_out);
        chk_vec("addr_write", 16'h0001, 16'(addr_write));
        chk_space("addr_space", OAG_SPACE_IRAM, addr_space);
        send(OAG_MODE_STACK, 8'h00, 3'h0, 1'h0, OAG_STK_PUSH, 2'h0);
        chk_vec("addr_out", 16'h0009, addr_out);
        send(OAG_MODE_STACK, 8'h00, 3'h0, 1'h0, OAG_STK_POP, 2'h0);
        chk_vec("addr_out", 16'h0009, addr_out);
        chk_vec("stack_ptr", 16'h0008, 16'(stack_ptr));
        $display("test stack done");
        // idle cycle gives no result
        @(negedge sys_clk);
        op_valid = 1'h0;
        sp_load = 1'h1;
        sp_load_val = 8'h30;
        @(posedge sys_clk);
        #1;
        chk_vec("addr_valid", 16'h0000, 16'(addr_valid));
        chk_vec("stack_ptr", 16'h0030, 16'(stack_ptr));
        send(OAG_MODE_INDIRECT, 8'h00, 3'h2, 1'h1, 2'h0, 2'h0);
        chk_vec("addr_out", 16'h0030, addr_out);
        chk_space("addr_space", OAG_SPACE_IRAM, addr_space);
        $display("test pointer load done");
        // write through indexed mode is refused
        send(OAG_MODE_INDEXED, 8'h00, 3'h0, 1'h1, 2'h0, 2'h0);
        chk_vec("addr_fault", 16'h0001, 16'(addr_fault));
        chk_vec("addr_write", 16'h0000, 16'(addr_write));
        send(OAG_MODE_REGSPEC, 8'h55, 3'h0, 1'h0, 2'h0, 2'h0);
        chk_vec("addr_valid", 16'h0001, 16'(addr_valid));
        chk_vec("fetch_operand", 16'h0000, 16'(fetch_operand));
        chk_vec("addr_fault", 16'h0000, 16'(addr_fault));
        $display("test refusal done");
        // reset in mid-run restores the stack pointer
        send(OAG_MODE_STACK, 8'h00, 3'h0, 1'h0, OAG_STK_PUSH, 2'h0);
        @(negedge sys_clk);
        op_valid = 1'h0;
        reset = 1'h1;
        @(posedge sys_clk);
        #1;
        chk_vec("stack_ptr", 16'h0007, 16'(stack_ptr));
        chk_vec("addr_valid", 16'h0000, 16'(addr_valid));
        @(negedge sys_clk);
        reset = 1'h0;
        send(OAG_MODE_DIRECT, 8'h90, 3'h0, 1'h0, 2'h0, 2'h0);
        chk_space("addr_space", OAG_SPACE_SPECIAL, addr_space);
        chk_vec("addr_out", 16'h0090, addr_out);
        chk_vec("stack_ptr", 16'h0007, 16'(stack_ptr));
        $display("test second reset done");
        test_done();
    end
endmodule : test_oag_top
